// ### logic/msl_device.sv
`timescale 1ns/1ps
`include "msl_defines.svh"
// Summary of operation
// - Six bit rates, 9600 after reset
// - Binary framing carries eight data bits
// - Text framing carries seven data bits
// - Even, odd or no parity; even default
// - With parity, exactly one stop bit
// - Without parity, two stop bits
// - Stop count one with even or odd parity, two with none
module msl_device
   import msl_pkg::*;
#(
   parameter int CLK_HZ = `MSL_CLK_HZ
) (
   // Link
   msl_if.dev LINK,
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   // Configuration
   input wire logic [2:0] BAUD_SEL,
   input wire logic ASCII_MODE,
   input wire logic [1:0] PARITY_SEL,
   input wire logic [7:0] SLAVE_ADDR,
   // Request bytes out
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic [7:0] RX_DATA,
   // Character events
   output logic PARITY_ERR,
   output logic FRAMING_ERR,
   output logic OVERRUN,
   // Response bytes in
   input wire logic TX_VALID,
   output logic TX_READY,
   input wire logic [7:0] TX_DATA,
   output logic TX_BUSY
);
   msl_cfg_t cfg;
   msl_cfg_t cfg_in;
   logic [16:0] div;
   logic [3:0] nbits;

   logic tx_busy;
   logic tx_oe;
   logic [16:0] tx_cnt;
   logic [3:0] tx_bit;
   logic [10:0] tx_sh;
   logic tx_tick;
   logic tx_last;
   logic tx_take;
   logic f_valid;
   logic [7:0] f_data;

   logic line_q;
   logic rx_busy;
   logic rx_done;
   logic [16:0] rx_cnt;
   logic [16:0] rx_tgt;
   logic [3:0] rx_bit;
   logic [10:0] rx_sh;
   logic rx_tick;
   logic [9:0] chk;
   logic [7:0] rx_byte;
   logic bad;

   logic [16:0] gap_cnt;
   logic [5:0] gap_bits;
   logic gap_hit;

   msl_fst_t st;
   msl_fst_t next_st;
   logic [3:0] adr_hi;
   logic [4:0] nib;
   logic addr_ok;
   logic rtu_match;
   logic asc_match;
   logic is_sof;
   logic push;
   logic stall;

   // Hex digit to {valid, value}
   function automatic logic [4:0] hex_nib(input logic [7:0] c);
      if (c >= "0" && c <= "9") return {1'b1, 4'(c - "0")};
      else if (c >= "A" && c <= "F") return {1'b1, 4'(c - "A" + 8'd10)};
      else if (c >= "a" && c <= "f") return {1'b1, 4'(c - "a" + 8'd10)};
      else return 5'h00;
   endfunction : hex_nib

   assign cfg_in = msl_cfg_t'({PARITY_SEL, ASCII_MODE, BAUD_SEL});
   assign div = msl_div(cfg.baud, CLK_HZ);
   assign nbits = msl_nbits(cfg);

   // Transmit side
   assign tx_tick = tx_busy && (tx_cnt == div - 17'h1);
   assign tx_last = tx_tick && (tx_bit == nbits - 4'h1);
   // No talking over an incoming character on the shared pair
   assign tx_take = f_valid && !rx_busy && (!tx_busy || tx_last);
   assign LINK.dev_tx = tx_sh[0];
   assign LINK.dev_oe = tx_oe;
   assign TX_BUSY = tx_oe;

   // Receive side, start bit sampled at mid-bit
   assign rx_tgt = (rx_bit == 4'h0) ? {1'b0, div[16:1]} : div;
   assign rx_tick = rx_busy && (rx_cnt == rx_tgt - 17'h1);
   assign chk = msl_unframe(rx_sh, cfg);
   assign rx_byte = chk[7:0];
   assign bad = chk[9] | chk[8];
   assign gap_hit = gap_bits == `MSL_GAP_BITS;

   // Address filter
   assign addr_ok = (SLAVE_ADDR >= `MSL_ADDR_MIN) && (SLAVE_ADDR <= `MSL_ADDR_MAX);
   assign nib = hex_nib(rx_byte);
   assign rtu_match = addr_ok && (rx_byte == SLAVE_ADDR);
   assign asc_match = addr_ok && nib[4] && ({adr_hi, nib[3:0]} == SLAVE_ADDR);
   assign is_sof = cfg.ascii && (rx_byte == `MSL_ASCII_SOF);
   assign push = rx_done && !bad && (st == MSL_F_PASS) && !is_sof;
   assign stall = RX_VALID && !RX_READY;

   always_comb begin
      next_st = st;
      if (rx_done && is_sof) begin
         next_st = MSL_F_ADDR;
      end else if (rx_done) begin
         case (st)
            MSL_F_ADDR: begin
               if (bad) next_st = MSL_F_SKIP;
               else if (cfg.ascii) next_st = nib[4] ? MSL_F_ALO : MSL_F_SKIP;
               else next_st = rtu_match ? MSL_F_PASS : MSL_F_SKIP;
            end
            MSL_F_ALO: next_st = (!bad && asc_match) ? MSL_F_PASS : MSL_F_SKIP;
            MSL_F_PASS: next_st = bad ? MSL_F_SKIP : MSL_F_PASS;
            default: next_st = st;
         endcase
      end else if (gap_hit && !cfg.ascii) begin
         next_st = MSL_F_ADDR;
      end
   end

   // Settings only change between characters
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) cfg <= MSL_CFG_RST;
      else if (CLK_EN && !tx_oe && !rx_busy && !tx_take) cfg <= cfg_in;
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         tx_busy <= 1'b0;
         tx_oe <= 1'b0;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_sh <= `MSL_IDLE_FRAME;
      end else if (CLK_EN) begin
         if (tx_take) begin
            tx_busy <= 1'b1;
            tx_oe <= 1'b1;
            tx_cnt <= '0;
            tx_bit <= '0;
            tx_sh <= msl_frame(f_data, cfg);
         end else if (tx_last) begin
            tx_busy <= 1'b0;
            tx_oe <= 1'b0;
            tx_sh <= `MSL_IDLE_FRAME;
         end else if (tx_tick) begin
            tx_cnt <= '0;
            tx_bit <= tx_bit + 4'h1;
            tx_sh <= {1'b1, tx_sh[10:1]};
         end else if (tx_busy) begin
            tx_cnt <= tx_cnt + 17'h1;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         line_q <= 1'b1;
         rx_busy <= 1'b0;
         rx_done <= 1'b0;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_sh <= `MSL_IDLE_FRAME;
      end else if (CLK_EN) begin
         line_q <= LINK.line;
         rx_done <= 1'b0;
         if (!rx_busy) begin
            if (line_q && !LINK.line && !tx_oe) begin
               rx_busy <= 1'b1;
               rx_cnt <= '0;
               rx_bit <= '0;
               rx_sh <= `MSL_IDLE_FRAME;
            end
         end else if (rx_tick) begin
            rx_cnt <= '0;
            rx_sh[rx_bit] <= LINK.line;
            rx_bit <= rx_bit + 4'h1;
            // A start bit gone high by mid-bit was a glitch
            if (rx_bit == 4'h0 && LINK.line) rx_busy <= 1'b0;
            else if (rx_bit == nbits - 4'h1) begin
               rx_busy <= 1'b0;
               rx_done <= 1'b1;
            end
         end else begin
            rx_cnt <= rx_cnt + 17'h1;
         end
      end
   end

   // Silence of three and a half characters ends a binary frame
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         gap_cnt <= '0;
         gap_bits <= '0;
      end else if (CLK_EN) begin
         if (rx_busy || !LINK.line) begin
            gap_cnt <= '0;
            gap_bits <= '0;
         end else if (!gap_hit) begin
            if (gap_cnt == div - 17'h1) begin
               gap_cnt <= '0;
               gap_bits <= gap_bits + 6'h1;
            end else begin
               gap_cnt <= gap_cnt + 17'h1;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st <= MSL_F_WAIT;
         adr_hi <= '0;
         RX_VALID <= 1'b0;
         RX_DATA <= '0;
         PARITY_ERR <= 1'b0;
         FRAMING_ERR <= 1'b0;
         OVERRUN <= 1'b0;
      end else if (CLK_EN) begin
         st <= next_st;
         if (rx_done && st == MSL_F_ADDR) adr_hi <= nib[3:0];
         PARITY_ERR <= rx_done && chk[9];
         FRAMING_ERR <= rx_done && chk[8];
         // The line cannot be held off, so a byte meeting a full slot is lost
         OVERRUN <= push && stall;
         if (push && !stall) begin
            RX_VALID <= 1'b1;
            RX_DATA <= rx_byte;
         end else if (RX_READY) begin
            RX_VALID <= 1'b0;
         end
      end
   end

   msl_fifo #(
      .W(8),
      .DEPTH(`MSL_FIFO_DEPTH)
   ) u_txq (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .ce(CLK_EN),
      .in_valid(TX_VALID),
      .in_ready(TX_READY),
      .in_data(TX_DATA),
      .out_valid(f_valid),
      .out_ready(tx_take),
      .out_data(f_data)
   );
endmodule : msl_device

// ### logic/msl_defines.svh
`ifndef MSL_DEFINES_SVH
`define MSL_DEFINES_SVH

`define MSL_CLK_HZ 250_000_000
`define MSL_BAUD_0 2_400
`define MSL_BAUD_1 4_800
`define MSL_BAUD_2 9_600
`define MSL_BAUD_3 14_400
`define MSL_BAUD_4 19_200
`define MSL_BAUD_5 38_400
`define MSL_BAUD_SEL_RST 3'h2
`define MSL_PAR_EVEN 2'h0
`define MSL_PAR_ODD 2'h1
`define MSL_PAR_NONE 2'h2
`define MSL_PAR_RSVD 2'h3
`define MSL_FRAME_BITS_RTU 4'hB
`define MSL_FRAME_BITS_ASCII 4'hA
`define MSL_IDLE_FRAME 11'h7FF
`define MSL_GAP_BITS 6'h27
`define MSL_ASCII_SOF 8'h3A
`define MSL_ADDR_MIN 8'h01
`define MSL_ADDR_MAX 8'hF7
`define MSL_FIFO_DEPTH 32
`define MSL_CFG_W 6
`define MSL_REG_CFG 4'h0
`define MSL_REG_TXD 4'h4
`define MSL_REG_RXD 4'h8
`define MSL_REG_STAT 4'hC
`define MSL_ST_TXBUSY 0
`define MSL_ST_RXV 1
`define MSL_ST_PERR 2
`define MSL_ST_FERR 3
`define MSL_ST_OVR 4
`define MSL_RXD_VALID 8

`endif

// ### logic/msl_pkg.sv
`include "msl_defines.svh"
package msl_pkg;
   typedef enum logic [1:0] {
      MSL_PAR_EVEN = `MSL_PAR_EVEN,
      MSL_PAR_ODD = `MSL_PAR_ODD,
      MSL_PAR_NONE = `MSL_PAR_NONE,
      MSL_PAR_RSVD = `MSL_PAR_RSVD
   } msl_par_t;

   typedef struct packed {
      msl_par_t par;
      logic ascii;
      logic [2:0] baud;
   } msl_cfg_t;

   typedef enum logic [4:0] {
      MSL_F_WAIT = 5'b00001,
      MSL_F_ADDR = 5'b00010,
      MSL_F_ALO = 5'b00100,
      MSL_F_PASS = 5'b01000,
      MSL_F_SKIP = 5'b10000
   } msl_fst_t;

   localparam msl_cfg_t MSL_CFG_RST = '{par: MSL_PAR_EVEN, ascii: 1'b0,
                                       baud: `MSL_BAUD_SEL_RST};

   function automatic logic [16:0] msl_div(input logic [2:0] sel, input int clk_hz);
      int rate;
      case (sel)
         3'h0: rate = `MSL_BAUD_0;
         3'h1: rate = `MSL_BAUD_1;
         3'h2: rate = `MSL_BAUD_2;
         3'h3: rate = `MSL_BAUD_3;
         3'h4: rate = `MSL_BAUD_4;
         default: rate = `MSL_BAUD_5;
      endcase
      return 17'((clk_hz + rate / 2) / rate);
   endfunction : msl_div

   function automatic logic msl_par_on(input msl_cfg_t c);
      return (c.par == MSL_PAR_EVEN) || (c.par == MSL_PAR_ODD);
   endfunction : msl_par_on

   // Parity or a second stop keeps every character of one framing the same length: 11 bits binary, 10 text
   function automatic logic [3:0] msl_nbits(input msl_cfg_t c);
      return c.ascii ? `MSL_FRAME_BITS_ASCII : `MSL_FRAME_BITS_RTU;
   endfunction : msl_nbits

   function automatic logic [10:0] msl_frame(input logic [7:0] d, input msl_cfg_t c);
      logic [10:0] f;
      logic p;
      f = `MSL_IDLE_FRAME;
      f[0] = 1'b0;
      p = (c.ascii ? ^d[6:0] : ^d) ^ (c.par == MSL_PAR_ODD);
      if (c.ascii) begin
         f[7:1] = d[6:0];
         if (msl_par_on(c)) f[8] = p;
      end else begin
         f[8:1] = d;
         if (msl_par_on(c)) f[9] = p;
      end
      return f;
   endfunction : msl_frame

   // Returns parity error, framing error, data
   function automatic logic [9:0] msl_unframe(input logic [10:0] f, input msl_cfg_t c);
      logic [7:0] d;
      logic pb;
      logic stop_a;
      logic stop_b;
      d = c.ascii ? {1'b0, f[7:1]} : f[8:1];
      pb = c.ascii ? f[8] : f[9];
      stop_a = c.ascii ? f[9] : f[10];
      stop_b = msl_par_on(c) || pb;
      return {msl_par_on(c) && (pb != ((^d) ^ (c.par == MSL_PAR_ODD))),
              !(stop_a && stop_b), d};
   endfunction : msl_unframe
endpackage : msl_pkg

// ### logic/msl_if.sv
`timescale 1ns/1ps
interface msl_if;
   logic dev_tx;
   logic dev_oe;
   logic host_tx;
   logic host_oe;
   logic line;

   // Undriven pair idles at mark through the fail-safe bias
   assign line = dev_oe ? dev_tx : (host_oe ? host_tx : 1'b1);

   modport dev (output dev_tx, output dev_oe, input line);
   modport host (output host_tx, output host_oe, input line);
endinterface : msl_if

// ### logic/msl_fifo.sv
`timescale 1ns/1ps
module msl_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   // Clock
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = count != (AW + 1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (ce && push) mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (ce) begin
         if (push) wr_ptr <= wr_ptr + AW'(1);
         if (pop) rd_ptr <= rd_ptr + AW'(1);
         if (push && !pop) count <= count + (AW + 1)'(1);
         else if (pop && !push) count <= count - (AW + 1)'(1);
      end
   end
endmodule : msl_fifo

// ### logic/msl_host.sv
`timescale 1ns/1ps
`include "msl_defines.svh"
module msl_host
   import msl_pkg::*;
#(
   parameter int CLK_HZ = `MSL_CLK_HZ
) (
   // Link
   msl_if.host LINK,
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   // Register port
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA
);
   msl_cfg_t cfg;
   logic [16:0] div;
   logic [3:0] nbits;
   logic [7:0] hold;
   logic hold_v;
   logic tx_busy;
   logic tx_oe;
   logic [16:0] tx_cnt;
   logic [3:0] tx_bit;
   logic [10:0] tx_sh;
   logic tx_tick;
   logic tx_last;
   logic tx_take;
   logic line_q;
   logic rx_busy;
   logic rx_done;
   logic [16:0] rx_cnt;
   logic [16:0] rx_tgt;
   logic [3:0] rx_bit;
   logic [10:0] rx_sh;
   logic rx_tick;
   logic [9:0] chk;
   logic [7:0] rx_data;
   logic rx_v;
   logic perr;
   logic ferr;
   logic ovr;
   logic wr_cfg;
   logic wr_txd;
   logic wr_stat;
   logic rd_rxd;
   logic [31:0] rd_mux;

   assign wr_cfg = WR && (ADDR == `MSL_REG_CFG);
   assign wr_txd = WR && (ADDR == `MSL_REG_TXD);
   assign wr_stat = WR && (ADDR == `MSL_REG_STAT);
   assign rd_rxd = RD && (ADDR == `MSL_REG_RXD);
   assign rd_mux = (ADDR == `MSL_REG_CFG) ? {26'h0, cfg} :
                   (ADDR == `MSL_REG_RXD) ? {23'h0, rx_v, rx_data} :
                   (ADDR == `MSL_REG_STAT) ? {27'h0, ovr, ferr, perr, rx_v, hold_v | tx_oe} :
                   32'h0000_0000;

   assign div = msl_div(cfg.baud, CLK_HZ);
   assign nbits = msl_nbits(cfg);
   assign tx_tick = tx_busy && (tx_cnt == div - 17'h1);
   assign tx_last = tx_tick && (tx_bit == nbits - 4'h1);
   assign tx_take = hold_v && !rx_busy && (!tx_busy || tx_last);
   assign LINK.host_tx = tx_sh[0];
   assign LINK.host_oe = tx_oe;
   assign rx_tgt = (rx_bit == 4'h0) ? {1'b0, div[16:1]} : div;
   assign rx_tick = rx_busy && (rx_cnt == rx_tgt - 17'h1);
   assign chk = msl_unframe(rx_sh, cfg);

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         cfg <= MSL_CFG_RST;
         hold <= '0;
         hold_v <= 1'b0;
         RDATA <= '0;
         rx_data <= '0;
         rx_v <= 1'b0;
         perr <= 1'b0;
         ferr <= 1'b0;
         ovr <= 1'b0;
      end else if (CLK_EN) begin
         RDATA <= RD ? rd_mux : 32'h0000_0000;
         if (wr_cfg) cfg <= msl_cfg_t'(WDATA[`MSL_CFG_W-1:0]);
         // A write into a full holding slot is dropped unless the shifter takes the held byte in the same cycle
         if (wr_txd && (!hold_v || tx_take)) begin
            hold <= WDATA[7:0];
            hold_v <= 1'b1;
         end else if (tx_take) begin
            hold_v <= 1'b0;
         end
         if (rx_done) begin
            rx_data <= chk[7:0];
            rx_v <= 1'b1;
         end else if (rd_rxd) begin
            rx_v <= 1'b0;
         end
         // Set beats write-one-to-clear
         perr <= (rx_done && chk[9]) || (perr && !(wr_stat && WDATA[`MSL_ST_PERR]));
         ferr <= (rx_done && chk[8]) || (ferr && !(wr_stat && WDATA[`MSL_ST_FERR]));
         ovr <= (rx_done && rx_v && !rd_rxd) || (ovr && !(wr_stat && WDATA[`MSL_ST_OVR]));
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         tx_busy <= 1'b0;
         tx_oe <= 1'b0;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_sh <= `MSL_IDLE_FRAME;
      end else if (CLK_EN) begin
         if (tx_take) begin
            tx_busy <= 1'b1;
            tx_oe <= 1'b1;
            tx_cnt <= '0;
            tx_bit <= '0;
            tx_sh <= msl_frame(hold, cfg);
         end else if (tx_last) begin
            tx_busy <= 1'b0;
            tx_oe <= 1'b0;
            tx_sh <= `MSL_IDLE_FRAME;
         end else if (tx_tick) begin
            tx_cnt <= '0;
            tx_bit <= tx_bit + 4'h1;
            tx_sh <= {1'b1, tx_sh[10:1]};
         end else if (tx_busy) begin
            tx_cnt <= tx_cnt + 17'h1;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         line_q <= 1'b1;
         rx_busy <= 1'b0;
         rx_done <= 1'b0;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_sh <= `MSL_IDLE_FRAME;
      end else if (CLK_EN) begin
         line_q <= LINK.line;
         rx_done <= 1'b0;
         if (!rx_busy) begin
            if (line_q && !LINK.line && !tx_oe) begin
               rx_busy <= 1'b1;
               rx_cnt <= '0;
               rx_bit <= '0;
               rx_sh <= `MSL_IDLE_FRAME;
            end
         end else if (rx_tick) begin
            rx_cnt <= '0;
            rx_sh[rx_bit] <= LINK.line;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && LINK.line) rx_busy <= 1'b0;
            else if (rx_bit == nbits - 4'h1) begin
               rx_busy <= 1'b0;
               rx_done <= 1'b1;
            end
         end else begin
            rx_cnt <= rx_cnt + 17'h1;
         end
      end
   end
endmodule : msl_host

// ### verif/msl_monitor.sv
`timescale 1ns/1ps
module msl_monitor (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // Pair
   input wire logic dev_tx,
   input wire logic dev_oe,
   input wire logic host_tx,
   input wire logic host_oe,
   input wire logic line
);
   logic [11:0] dev_len;
   logic [11:0] host_len;
   logic [11:0] dev_hi;
   logic [11:0] host_hi;
   wire [11:0] next_dev_len = dev_oe ? dev_len + 12'h001 : 12'h000;
   wire [11:0] next_host_len = host_oe ? host_len + 12'h001 : 12'h000;
   wire [11:0] next_dev_hi = (dev_oe && line) ? dev_hi + 12'h001 : 12'h000;
   wire [11:0] next_host_hi = (host_oe && host_tx) ? host_hi + 12'h001 : 12'h000;

   // Run lengths of drive and of high level, enough for one full run of 33 chars
   always_ff @(posedge SYS_CLK) begin
      dev_len <= RST_N ? next_dev_len : 12'h000;
      host_len <= RST_N ? next_host_len : 12'h000;
      dev_hi <= RST_N ? next_dev_hi : 12'h000;
      host_hi <= RST_N ? next_host_hi : 12'h000;
   end

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   // Shortest bit used anywhere is five cycles
   sequence low5_s(x);
      !x [*5];
   endsequence
   sequence hold4_s(x);
      $stable(x) [*4];
   endsequence

   reset_release_a: assert property (disable iff (1'b0) !RST_N |=> !dev_oe && !host_oe)
      else $error("link still driven after reset");
   dev_start_a: assert property ($rose(dev_oe) |-> low5_s(dev_tx))
      else $error("device start bit too short");
   host_start_a: assert property ($rose(host_oe) |-> low5_s(host_tx))
      else $error("host start bit too short");
   dev_bit_hold_a: assert property ($changed(dev_tx) && dev_oe |=> hold4_s(dev_tx))
      else $error("device bit shorter than a bit time");
   dev_stop_a: assert property ($fell(dev_oe) |-> dev_hi >= 12'h004)
      else $error("device released without a stop bit");
   host_stop_a: assert property ($fell(host_oe) |-> host_hi >= 12'h004)
      else $error("host released without a stop bit");
   dev_len_a: assert property ($fell(dev_oe) |-> dev_len >= 12'h030)
      else $error("device character too short");
   host_len_a: assert property ($fell(host_oe) |-> host_len >= 12'h030)
      else $error("host character too short");
   no_overlap_a: assert property (!(dev_oe && host_oe))
      else $error("both ends drive the pair");
endmodule : msl_monitor

// ### verif/modbus_serial_link_config_tb.sv
`timescale 1ns/1ps
module modbus_serial_link_config_tb;
   import msl_pkg::*;
   localparam int CLK = 192_000;
   localparam int RATES [6] = '{2400, 4800, 9600, 14400, 19200, 38400};
   // Rows: baud, ascii, parity, data byte
   localparam logic [13:0] ROWS [8] = '{{3'h0, 1'b0, 2'h0, 8'hA5}, {3'h1, 1'b0, 2'h1, 8'h3C},
      {3'h2, 1'b0, 2'h2, 8'h81}, {3'h3, 1'b1, 2'h0, 8'hF1}, {3'h4, 1'b1, 2'h1, 8'h55},
      {3'h5, 1'b1, 2'h2, 8'h0F}, {3'h2, 1'b1, 2'h3, 8'hC3}, {3'h5, 1'b0, 2'h3, 8'h00}};
   logic SYS_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic CLK_EN = 1'b1;
   logic [2:0] BAUD_SEL = 3'h2;
   logic ASCII_MODE = 1'b0;
   logic [1:0] PARITY_SEL = 2'h0;
   logic [7:0] SLAVE_ADDR = 8'h11;
   logic RX_VALID;
   logic RX_READY = 1'b1;
   logic [7:0] RX_DATA;
   logic PARITY_ERR;
   logic TX_VALID = 1'b0;
   logic TX_READY;
   logic [7:0] TX_DATA = 8'h00;
   logic TX_BUSY;
   logic [3:0] ADDR = 4'h0;
   logic [31:0] WDATA = 32'h0000_0000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [31:0] RDATA;
   int n_errors = 0;
   int samples_checked = 0;
   int rx_cnt = 0;
   int perr_cnt = 0;
   logic [7:0] rx_last;
   time t_rise;
   time t_fall;

   msl_if msl_if_inst ();
   msl_device #(.CLK_HZ(CLK)) msl_device_inst (.LINK(msl_if_inst.dev), .SYS_CLK(SYS_CLK),
      .RST_N(RST_N), .CLK_EN(CLK_EN), .BAUD_SEL(BAUD_SEL), .ASCII_MODE(ASCII_MODE),
      .PARITY_SEL(PARITY_SEL), .SLAVE_ADDR(SLAVE_ADDR), .RX_VALID(RX_VALID),
      .RX_READY(RX_READY), .RX_DATA(RX_DATA), .PARITY_ERR(PARITY_ERR), .FRAMING_ERR(),
      .OVERRUN(), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_BUSY(TX_BUSY));
   msl_host #(.CLK_HZ(CLK)) msl_host_inst (.LINK(msl_if_inst.host), .SYS_CLK(SYS_CLK),
      .RST_N(RST_N), .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA));
   msl_monitor msl_monitor_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .dev_tx(msl_if_inst.dev_tx), .dev_oe(msl_if_inst.dev_oe),
      .host_tx(msl_if_inst.host_tx), .host_oe(msl_if_inst.host_oe), .line(msl_if_inst.line));

   always #2 SYS_CLK = ~SYS_CLK;
   always @(posedge msl_if_inst.dev_oe) t_rise = $time;
   always @(negedge msl_if_inst.dev_oe) t_fall = $time;
   // Request bytes are only one cycle long while ready is held high
   always @(posedge SYS_CLK) begin
      if (RX_VALID === 1'b1) begin
         rx_cnt++;
         rx_last = RX_DATA;
      end
      if (PARITY_ERR === 1'b1) perr_cnt++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      @(negedge SYS_CLK);
      q = RDATA;
   endtask : rd

   task automatic set_cfg(input logic [2:0] b, input logic a, input logic [1:0] p);
      @(posedge SYS_CLK);
      BAUD_SEL <= b;
      ASCII_MODE <= a;
      PARITY_SEL <= p;
      wr(4'h0, {26'h0, p, a, b});
   endtask : set_cfg

   // Waits until the hold and the shifter are both empty
   task automatic host_tx(input logic [7:0] d);
      logic [31:0] q;
      int k;
      k = 0;
      wr(4'h4, {24'h0, d});
      do begin
         rd(4'hC, q);
         k++;
      end while (q[0] && k < 3000);
      if (q[0]) n_errors++;
   endtask : host_tx

   task automatic dev_char(input logic [7:0] d, input int dv, output logic [10:0] f);
      int k;
      @(posedge SYS_CLK);
      TX_VALID <= 1'b1;
      TX_DATA <= d;
      @(posedge SYS_CLK);
      TX_VALID <= 1'b0;
      f = '1;
      k = 0;
      while (!msl_if_inst.dev_oe && k < 50) begin
         @(negedge SYS_CLK);
         k++;
      end
      if (k >= 50) n_errors++;
      k = 0;
      while (msl_if_inst.dev_oe && k < 4000) begin
         if (k % dv == dv / 2 && k / dv < 11) f[k / dv] = msl_if_inst.line;
         @(negedge SYS_CLK);
         k++;
      end
   endtask : dev_char

   function automatic logic [10:0] exp_frame(input logic [7:0] d, input logic a,
                                             input logic [1:0] p);
      logic [10:0] f;
      int n;
      f = '1;
      f[0] = 1'b0;
      n = a ? 7 : 8;
      for (int i = 0; i < n; i++) f[1 + i] = d[i];
      if (p < 2'h2) f[1 + n] = ^(d & (a ? 8'h7F : 8'hFF)) ^ p[0];
      return f;
   endfunction : exp_frame

   task automatic report_and_stop;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (60000) @(posedge SYS_CLK);
      n_errors++;
      report_and_stop();
   end

   initial begin
      logic [31:0] q;
      logic [10:0] f;
      logic [2:0] b;
      logic a;
      logic [1:0] p;
      logic [7:0] d;
      int dv;
      int nb;
      int dur;
      int c0;
      int acc;
      repeat (6) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      wr(4'h6, 32'hFFFF_FFFF);
      rd(4'h0, q);
      chk(q, 32'h0000_0002);
      rd(4'h6, q);
      chk(q, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         {b, a, p, d} = ROWS[i];
         set_cfg(b, a, p);
         dv = (CLK + RATES[b] / 2) / RATES[b];
         nb = a ? 10 : 11;
         dev_char(d, dv, f);
         dur = int'((t_fall - t_rise) / 4);
         chk(f, exp_frame(d, a, p));
         chk(dur == nb * dv || dur == nb * dv + 1, 1);
         rd(4'hC, q);
         chk(q, 32'h0000_0002);
         rd(4'h8, q);
         chk(q, {23'h0, 1'b1, a ? {1'b0, d[6:0]} : d});
      end
      // Address filter, then a foreign address, then a parity mismatch
      set_cfg(3'h2, 1'b0, 2'h0);
      repeat (900) @(posedge SYS_CLK);
      c0 = rx_cnt;
      host_tx(8'h11);
      host_tx(8'hA5);
      repeat (40) @(posedge SYS_CLK);
      chk(rx_cnt - c0, 1);
      chk(rx_last, 8'hA5);
      repeat (900) @(posedge SYS_CLK);
      host_tx(8'h22);
      host_tx(8'h5A);
      repeat (900) @(posedge SYS_CLK);
      wr(4'h0, 32'h0000_0012);
      host_tx(8'h11);
      repeat (40) @(posedge SYS_CLK);
      chk(rx_cnt - c0, 1);
      chk(perr_cnt, 1);
      // Fill the response queue at the top rate while the host never reads
      set_cfg(3'h5, 1'b0, 2'h0);
      acc = 0;
      @(posedge SYS_CLK);
      TX_VALID <= 1'b1;
      repeat (40) begin
         @(negedge SYS_CLK);
         if (TX_READY === 1'b1) acc++;
         @(posedge SYS_CLK);
         TX_DATA <= TX_DATA + 8'h01;
      end
      TX_VALID <= 1'b0;
      dur = 0;
      while (msl_if_inst.dev_oe && dur < 3000) begin
         @(negedge SYS_CLK);
         dur++;
      end
      dur = int'((t_fall - t_rise) / 4);
      chk(acc, 33);
      chk(dur == 1815 || dur == 1816, 1);
      rd(4'hC, q);
      chk(q, 32'h0000_0012);
      // Text framing: colon, two hex digits of our address, one data character
      set_cfg(3'h5, 1'b1, 2'h0);
      c0 = rx_cnt;
      host_tx(8'h3A);
      host_tx(8'h31);
      host_tx(8'h31);
      host_tx(8'h51);
      repeat (40) @(posedge SYS_CLK);
      chk(rx_cnt - c0, 1);
      chk(rx_last, 8'h51);
      // Reset in the middle of a character
      TX_DATA <= 8'h96;
      TX_VALID <= 1'b1;
      @(posedge SYS_CLK);
      TX_VALID <= 1'b0;
      repeat (30) @(posedge SYS_CLK);
      chk(TX_BUSY, 1'b1);
      RST_N <= 1'b0;
      repeat (6) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      @(negedge SYS_CLK);
      chk(msl_if_inst.dev_oe, 1'b0);
      chk(TX_BUSY, 1'b0);
      rd(4'h0, q);
      chk(q, 32'h0000_0002);
      report_and_stop();
   end
endmodule : modbus_serial_link_config_tb
